// [core/mmd_decode_arbiter.sv]
`include "mmd_map.svh"
module mmd_decode_arbiter #(
   parameter logic [31:0] ram_size_bytes   = 32'h0000_1800,
   parameter logic [31:0] flash_size_bytes = 32'h0001_0000,
   parameter logic [31:0] nvm_size_bytes   = 32'h0000_4000
) (
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   mmd_if.device            bus,
   input  wire logic        single_chip_in,
   output logic             tgt_valid_out,
   output logic             tgt_wr_out,
   output logic             tgt_word_out,
   output logic [17:0]      tgt_addr_out,
   output logic [15:0]      tgt_wdata_out,
   output logic [5:0]       tgt_sel_out,
   input  wire logic        tgt_ready_in,
   input  wire logic [15:0] tgt_rdata_in,
   output logic             illegal_reset_out,
   output logic             irq_out
);
   localparam logic [17:0] ram_bot = 18'(32'h4000 - ram_size_bytes);
   // Flash bottom from size
   localparam logic [18:0] flash_end = `MMD_PFL_END;
   localparam logic [17:0] program_flash_bottom_address =
      18'(flash_end - 19'(flash_size_bytes));
   localparam logic [17:0] nvm_bot = 18'(32'h4000 - nvm_size_bytes);

   typedef struct packed {
      logic [7:0]              page;
      mmd_pkg::mmd_arb_e       arb;
      logic                    owner_dbg;
      logic [7:0]              dbg_wait;
      logic                    tgt_valid;
      logic                    tgt_wr;
      logic                    tgt_word;
      mmd_pkg::mmd_gaddr_t     tgt_addr;
      logic [15:0]             tgt_wdata;
      logic [5:0]              tgt_sel;
      logic                    cpu_ack;
      logic [15:0]             cpu_rdata;
      logic                    dbg_ack;
      logic [15:0]             dbg_rdata;
      logic                    illegal;
      logic                    swap;
   } mmd_state_s;

   mmd_state_s st;
   mmd_state_s next_st;

   // Region decode, used for both masters
   function automatic mmd_pkg::mmd_target_e decode(input logic [17:0] a);
      mmd_pkg::mmd_target_e t;
      t = mmd_pkg::MMD_T_NONE;
      if (a <= `MMD_REG_TOP) begin
         t = mmd_pkg::MMD_T_REG;
      end else if (a >= `MMD_DFL_BOT && a <= `MMD_DFL_TOP) begin
         t = mmd_pkg::MMD_T_DFL;
      end else if (a >= ram_bot && a <= `MMD_RAM_TOP) begin
         t = mmd_pkg::MMD_T_RAM;
      end else if (a[17:14] == 4'(`MMD_NVM_PAGE) && a[13:0] >= nvm_bot[13:0]
                   && !(a >= `MMD_DFL_BOT && a <= `MMD_DFL_TOP)) begin
         t = mmd_pkg::MMD_T_NVM;
      end else if (a >= program_flash_bottom_address) begin
         t = mmd_pkg::MMD_T_PFL;
      end
      return t;
   endfunction

   // Local to global translation
   function automatic logic [17:0] to_global(input logic [15:0] la,
                                             input logic [7:0] pg);
      logic [17:0] g;
      g = 18'h0_0000;
      if (la >= `MMD_WIN_BOT && la <= `MMD_WIN_TOP) begin
         g = {pg[3:0], la[13:0]};
      end else if (la < 16'h4000) begin
         g = {4'hc, la[13:0]};
         if (la < 16'h4000 && {4'h0, la[13:0]} <= `MMD_RAM_TOP)
            g = {4'h0, la[13:0]};
      end else if (la < `MMD_WIN_BOT) begin
         g = {4'hd, la[13:0]};
      end else begin
         g = {4'hf, la[13:0]};
      end
      return g;
   endfunction

   logic [17:0]          cpu_g;
   mmd_pkg::mmd_target_e cpu_t;
   mmd_pkg::mmd_target_e dbg_t;
   assign cpu_g = to_global(bus.cpu_addr, st.page);
   assign cpu_t = decode(cpu_g);
   assign dbg_t = decode(bus.dbg_addr);

   always_comb begin
      next_st = st;
      next_st.cpu_ack = 1'b0;
      next_st.dbg_ack = 1'b0;
      if (bus.cpu_page_wr)
         next_st.page = bus.cpu_page_val;
      if (bus.dbg_req && !st.owner_dbg && st.dbg_wait != 8'hff)
         next_st.dbg_wait = st.dbg_wait + 8'h01;
      case (st.arb)
         mmd_pkg::MMD_ARB_IDLE: begin
            if (bus.dbg_req && (!bus.cpu_req ||
                st.dbg_wait > `MMD_DBG_WAIT_MAX) && !bus.cpu_busy) begin
               next_st.owner_dbg = 1'b1;
               next_st.dbg_wait = 8'h00;
               if (dbg_t == mmd_pkg::MMD_T_NONE) begin
                  next_st.dbg_ack = 1'b1;
                  next_st.dbg_rdata = 16'h0000;
                  next_st.arb = mmd_pkg::MMD_ARB_DRAIN;
               end else begin
                  next_st.tgt_valid = 1'b1;
                  next_st.tgt_wr = bus.dbg_wr;
                  next_st.tgt_word = bus.dbg_word;
                  next_st.tgt_addr = bus.dbg_addr;
                  next_st.tgt_wdata = bus.dbg_wdata;
                  next_st.tgt_sel = 6'(1) << dbg_t;
                  next_st.arb = mmd_pkg::MMD_ARB_DBG;
               end
            end else if (bus.cpu_req) begin
               next_st.owner_dbg = 1'b0;
               if (cpu_t == mmd_pkg::MMD_T_NONE) begin
                  if (single_chip_in && !bus.cpu_fw_cmd)
                     next_st.illegal = 1'b1;
                  next_st.cpu_ack = 1'b1;
                  next_st.cpu_rdata = 16'h0000;
                  next_st.arb = mmd_pkg::MMD_ARB_DRAIN;
               end else begin
                  next_st.tgt_valid = 1'b1;
                  next_st.tgt_wr = bus.cpu_wr;
                  next_st.tgt_word = bus.cpu_word;
                  next_st.tgt_addr = cpu_g;
                  next_st.tgt_wdata = bus.cpu_wdata;
                  next_st.tgt_sel = 6'(1) << cpu_t;
                  next_st.swap = bus.cpu_word ? 1'b0 : cpu_g[0];
                  next_st.arb = mmd_pkg::MMD_ARB_CPU;
               end
            end
         end
         mmd_pkg::MMD_ARB_CPU,
         mmd_pkg::MMD_ARB_DBG: begin
            if (tgt_ready_in) begin
               next_st.tgt_valid = 1'b0;
               next_st.tgt_sel = 6'h00;
               if (st.arb == mmd_pkg::MMD_ARB_CPU) begin
                  next_st.cpu_ack = 1'b1;
                  next_st.cpu_rdata = st.swap ?
                     {tgt_rdata_in[7:0], tgt_rdata_in[15:8]} : tgt_rdata_in;
               end else begin
                  next_st.dbg_ack = 1'b1;
                  next_st.dbg_rdata = tgt_rdata_in;
               end
               next_st.arb = mmd_pkg::MMD_ARB_DRAIN;
            end
         end
         mmd_pkg::MMD_ARB_DRAIN: begin
            // Gap cycle lets masters drop request after ack
            next_st.arb = mmd_pkg::MMD_ARB_IDLE;
         end
         default: next_st.arb = mmd_pkg::MMD_ARB_IDLE;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st <= '0;
         st.page <= `MMD_PAGE_RST;
         st.arb <= mmd_pkg::MMD_ARB_IDLE;
      end else begin
         st <= next_st;
      end
   end

   assign bus.cpu_ack = st.cpu_ack;
   assign bus.cpu_rdata = st.cpu_rdata;
   assign bus.dbg_ack = st.dbg_ack;
   assign bus.dbg_rdata = st.dbg_rdata;
   assign bus.page = st.page;
   assign tgt_valid_out = st.tgt_valid;
   assign tgt_wr_out = st.tgt_wr;
   assign tgt_word_out = st.tgt_word;
   assign tgt_addr_out = st.tgt_addr;
   assign tgt_wdata_out = st.tgt_wdata;
   assign tgt_sel_out = st.tgt_sel;
   assign illegal_reset_out = st.illegal;
   assign irq_out = 1'b0;
endmodule

// [core/mmd_masters.sv]
`include "mmd_map.svh"
module mmd_masters (
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   mmd_if.master            bus,
   input  wire logic        cpu_req_in,
   input  wire logic [15:0] cpu_addr_in,
   input  wire logic        cpu_wr_in,
   input  wire logic        cpu_word_in,
   input  wire logic        cpu_fw_cmd_in,
   input  wire logic [15:0] cpu_wdata_in,
   input  wire logic        call_in,
   input  wire logic        call_indirect_in,
   input  wire logic [7:0]  call_page_in,
   input  wire logic [15:0] call_ret_addr_in,
   input  wire logic        dbg_req_in,
   input  wire logic [17:0] dbg_addr_in,
   input  wire logic        dbg_wr_in,
   input  wire logic        dbg_word_in,
   input  wire logic [15:0] dbg_wdata_in,
   output logic             cpu_done_out,
   output logic [15:0]      cpu_rdata_out,
   output logic             dbg_done_out,
   output logic [15:0]      dbg_rdata_out,
   output logic             dbg_blocked_out,
   output logic [7:0]       saved_page_out,
   output logic [15:0]      push_ret_out,
   output logic             irq_inhibit_out
);
   typedef enum logic [1:0] {
      MMD_C_IDLE, MMD_C_FETCH, MMD_C_PUSH
   } mmd_call_e;
   typedef struct packed {
      mmd_call_e   cs;
      logic [7:0]  saved;
      logic [7:0]  newpg;
      logic [15:0] ret;
      logic        pg_wr;
   } mmd_mst_s;
   mmd_mst_s st;
   mmd_mst_s next_st;
   logic misaligned;
   assign misaligned = dbg_word_in && dbg_addr_in[0];

   always_comb begin
      next_st = st;
      next_st.pg_wr = 1'b0;
      case (st.cs)
         MMD_C_IDLE: begin
            if (call_in) begin
               next_st.saved = bus.page;
               next_st.ret = call_ret_addr_in;
               next_st.newpg = call_page_in;
               if (call_indirect_in) begin
                  next_st.cs = MMD_C_FETCH;
               end else begin
                  next_st.pg_wr = 1'b1;
                  next_st.cs = MMD_C_PUSH;
               end
            end
         end
         MMD_C_FETCH: begin
            if (bus.cpu_ack) begin
               next_st.newpg = bus.cpu_rdata[7:0];
               next_st.pg_wr = 1'b1;
               next_st.cs = MMD_C_PUSH;
            end
         end
         MMD_C_PUSH: next_st.cs = MMD_C_IDLE;
         default: next_st.cs = MMD_C_IDLE;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in)
         st <= '0;
      else
         st <= next_st;
   end

   assign bus.cpu_req = cpu_req_in;
   assign bus.cpu_addr = cpu_addr_in;
   assign bus.cpu_wr = cpu_wr_in;
   assign bus.cpu_word = cpu_word_in;
   assign bus.cpu_fw_cmd = cpu_fw_cmd_in;
   assign bus.cpu_wdata = cpu_wdata_in;
   assign bus.cpu_page_wr = st.pg_wr;
   assign bus.cpu_page_val = st.newpg;
   // Debug is held off while a far call is in fetch or push, not in the cycle call_in is taken
   assign bus.cpu_busy = (st.cs != MMD_C_IDLE);
   assign bus.dbg_req = dbg_req_in && !misaligned;
   assign bus.dbg_addr = dbg_addr_in;
   assign bus.dbg_wr = dbg_wr_in;
   assign bus.dbg_word = dbg_word_in;
   assign bus.dbg_wdata = dbg_wdata_in;
   assign cpu_done_out = bus.cpu_ack;
   assign cpu_rdata_out = bus.cpu_rdata;
   assign dbg_done_out = bus.dbg_ack;
   assign dbg_rdata_out = bus.dbg_rdata;
   assign dbg_blocked_out = dbg_req_in && misaligned;
   assign saved_page_out = st.saved;
   assign push_ret_out = st.ret;
   assign irq_inhibit_out = (st.cs != MMD_C_IDLE) || call_in;
endmodule

// [include/mmd_if.sv]
interface mmd_if;
   logic        cpu_req;
   logic [15:0] cpu_addr;
   logic        cpu_wr;
   logic        cpu_word;
   logic        cpu_fw_cmd;
   logic [15:0] cpu_wdata;
   logic        cpu_page_wr;
   logic [7:0]  cpu_page_val;
   logic        cpu_busy;
   logic        cpu_ack;
   logic [15:0] cpu_rdata;
   logic        dbg_req;
   logic [17:0] dbg_addr;
   logic        dbg_wr;
   logic        dbg_word;
   logic [15:0] dbg_wdata;
   logic        dbg_ack;
   logic [15:0] dbg_rdata;
   logic [7:0]  page;
   modport device (
      input  cpu_req, cpu_addr, cpu_wr, cpu_word, cpu_fw_cmd, cpu_wdata,
      input  cpu_page_wr, cpu_page_val, cpu_busy,
      input  dbg_req, dbg_addr, dbg_wr, dbg_word, dbg_wdata,
      output cpu_ack, cpu_rdata, dbg_ack, dbg_rdata, page
   );
   modport master (
      output cpu_req, cpu_addr, cpu_wr, cpu_word, cpu_fw_cmd, cpu_wdata,
      output cpu_page_wr, cpu_page_val, cpu_busy,
      output dbg_req, dbg_addr, dbg_wr, dbg_word, dbg_wdata,
      input  cpu_ack, cpu_rdata, dbg_ack, dbg_rdata, page
   );
endinterface

// [include/mmd_map.svh]
`ifndef MMD_MAP_SVH
`define MMD_MAP_SVH
// Global address map, 18-bit global addresses
`define MMD_GADDR_W        18
`define MMD_LADDR_W        16
`define MMD_REG_BOT        18'h0_0000
`define MMD_REG_TOP        18'h0_03ff
`define MMD_RAM_TOP        18'h0_3fff
`define MMD_RAM_END        18'h0_4000
`define MMD_DFL_BOT        18'h0_4400
`define MMD_DFL_TOP        18'h0_53ff
`define MMD_NVM_PAGE       8'h01
`define MMD_PFL_TOP        18'h3_ffff
`define MMD_PFL_END        19'h4_0000
`define MMD_RAM_MAX        32'h0000_2c00
`define MMD_PFL_MAX        32'h0003_8000
`define MMD_NVM_MAX        32'h0000_4000
`define MMD_PAGE_RST       8'h0e
`define MMD_WIN_BOT        16'h8000
`define MMD_WIN_TOP        16'hbfff
`define MMD_DBG_WAIT_MAX   8'd128
`endif

// [include/mmd_pkg.sv]
package mmd_pkg;
   typedef enum logic [2:0] {
      MMD_T_NONE, MMD_T_REG, MMD_T_RAM, MMD_T_DFL, MMD_T_NVM, MMD_T_PFL
   } mmd_target_e;
   typedef enum logic [1:0] {
      MMD_ARB_IDLE, MMD_ARB_CPU, MMD_ARB_DBG, MMD_ARB_DRAIN
   } mmd_arb_e;
   typedef logic [17:0] mmd_gaddr_t;
endpackage

// [testbench/memory_map_decode_arbiter_tb.sv]
module memory_map_decode_arbiter_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_in = 1'b0, rst_n = 1'b0, rdy = 1'b0;
   logic cpu_req = 1'b0, cpu_word = 1'b0, cpu_fw = 1'b0;
   logic call = 1'b0, call_ind = 1'b0, dbg_req = 1'b0, dbg_word = 1'b0;
   logic [15:0] cpu_addr = 16'h0000, ret = 16'h0000, tdata = 16'h0000;
   logic [17:0] dbg_addr = 18'h0_0000, t_addr, addr_seen;
   logic [7:0] cpage = 8'h00, saved;
   logic [15:0] c_rd, d_rd, push;
   logic [5:0] sel, sel_seen;
   logic c_done, d_done, t_valid, illegal, irq;
   logic t_word, t_wr, word_seen, wr_seen, blocked, inh;
   logic cpu_wr = 1'b0, sc = 1'b1;
   logic [15:0] t_wd, wd_seen;
   int errors = 0, check_count = 0, cycles = 0;
   mmd_if link ();
   mmd_decode_arbiter u_mmd_decode_arbiter (.clk_in(clk_in),
      .rst_n_in(rst_n), .bus(link), .single_chip_in(sc),
      .tgt_valid_out(t_valid), .tgt_wr_out(t_wr), .tgt_word_out(t_word),
      .tgt_addr_out(t_addr), .tgt_wdata_out(t_wd), .tgt_sel_out(sel),
      .tgt_ready_in(rdy), .tgt_rdata_in(tdata),
      .illegal_reset_out(illegal), .irq_out(irq));
   mmd_masters u_mmd_masters (.clk_in(clk_in), .rst_n_in(rst_n),
      .bus(link), .cpu_req_in(cpu_req), .cpu_addr_in(cpu_addr),
      .cpu_wr_in(cpu_wr), .cpu_word_in(cpu_word), .cpu_fw_cmd_in(cpu_fw),
      .cpu_wdata_in(16'hc3a5), .call_in(call), .call_indirect_in(call_ind),
      .call_page_in(cpage), .call_ret_addr_in(ret), .dbg_req_in(dbg_req),
      .dbg_addr_in(dbg_addr), .dbg_wr_in(1'b0), .dbg_word_in(dbg_word),
      .dbg_wdata_in(16'h0000), .cpu_done_out(c_done),
      .cpu_rdata_out(c_rd), .dbg_done_out(d_done), .dbg_rdata_out(d_rd),
      .dbg_blocked_out(blocked), .saved_page_out(saved),
      .push_ret_out(push), .irq_inhibit_out(inh));
   mmd_link_props u_props (.clk_in(clk_in), .rst_n_in(rst_n),
      .cpu_req(link.cpu_req), .cpu_ack(link.cpu_ack),
      .cpu_page_wr(link.cpu_page_wr), .cpu_page_val(link.cpu_page_val),
      .dbg_req(link.dbg_req), .dbg_word(link.dbg_word),
      .dbg_addr(link.dbg_addr), .dbg_ack(link.dbg_ack), .page(link.page));
   always #2.5 clk_in = ~clk_in;
   // Target answers one cycle after valid; idle data is inverted
   always @(posedge clk_in) begin
      #1;
      rdy = t_valid && !rdy;
      tdata = rdy ? 16'h1234 : 16'hedcb;
      if (t_valid) begin
         sel_seen = sel;
         addr_seen = t_addr;
         word_seen = t_word;
         wr_seen = t_wr;
         wd_seen = t_wd;
      end
   end
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         results();
      end
   end
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk_in);
      #1;
   endtask
   // One access; request held until its answer is seen
   task automatic go(input bit d, input logic [17:0] a, input logic w,
                     input logic f);
      int n;
      tick(1);
      sel_seen = 6'h00;
      addr_seen = 18'h0_0000;
      if (d) begin
         dbg_addr = a;
         dbg_word = w;
         dbg_req = 1'b1;
      end else begin
         cpu_addr = a[15:0];
         cpu_word = w;
         cpu_fw = f;
         cpu_req = 1'b1;
      end
      n = 0;
      do begin
         tick(1);
         n++;
      end while ((d ? d_done : c_done) !== 1'b1 && n < 50);
      dbg_req = 1'b0;
      cpu_req = 1'b0;
      check("answer", n < 50, 1);
   endtask
   task automatic t_map();
      logic [17:0] a [12] = '{18'h0_0000, 18'h0_03ff, 18'h0_0400,
         18'h0_27ff, 18'h0_2800, 18'h0_3fff, 18'h0_4400, 18'h0_53ff,
         18'h2_ffff, 18'h3_0000, 18'h0_4000, 18'h0_7fff};
      logic [5:0] e [12] = '{6'h02, 6'h02, 6'h00, 6'h00, 6'h04, 6'h04,
         6'h08, 6'h08, 6'h00, 6'h20, 6'h10, 6'h10};
      for (int i = 0; i < 12; i++) begin
         go(1'b1, a[i], !a[i][0], 1'b0);
         check("select", sel_seen, e[i]);
         if (e[i] != 6'h00) begin
            check("target address", addr_seen, a[i]);
            check("target width", word_seen, !a[i][0]);
         end else begin
            check("debug unmapped data", d_rd, 16'h0000);
         end
      end
      check("no reset on debug", illegal, 0);
      cpu_wr = 1'b1;
      go(1'b0, 18'h0_3000, 1'b1, 1'b0);
      cpu_wr = 1'b0;
      check("write strobe", wr_seen, 1);
      check("write data", wd_seen, 16'hc3a5);
      check("ram address", addr_seen, 18'h0_3000);
      $display("map test done");
   endtask
   task automatic t_align();
      tick(1);
      dbg_addr = 18'h0_2801;
      dbg_word = 1'b1;
      dbg_req = 1'b1;
      tick(1);
      check("blocked flag", blocked, 1);
      check("request held back", link.dbg_req, 0);
      tick(3);
      check("no debug answer", d_done, 0);
      check("no target cycle", t_valid, 0);
      dbg_req = 1'b0;
      $display("align test done");
   endtask
   task automatic t_call();
      go(1'b0, 18'h0_8002, 1'b1, 1'b0);
      check("window address", addr_seen, 18'h3_8002);
      check("word data", c_rd, 16'h1234);
      go(1'b0, 18'h0_8001, 1'b0, 1'b0);
      check("swapped byte", c_rd, 16'h3412);
      cpage = 8'h0c;
      ret = 16'h4321;
      call = 1'b1;
      tick(1);
      check("call masks interrupts", inh, 1);
      call = 1'b0;
      for (int n = 0; n < 20 && link.page !== 8'h0c; n++)
         tick(1);
      check("new page", link.page, 8'h0c);
      check("call over", inh, 0);
      check("saved page", saved, 8'h0e);
      check("return address", push, 16'h4321);
      go(1'b0, 18'h0_8004, 1'b1, 1'b0);
      check("paged address", addr_seen, 18'h3_0004);
      call_ind = 1'b1;
      call = 1'b1;
      tick(1);
      check("fetch masks interrupts", inh, 1);
      call = 1'b0;
      go(1'b0, 18'h0_8000, 1'b1, 1'b0);
      call_ind = 1'b0;
      tick(3);
      check("fetched page", link.page, 8'h34);
      $display("call test done");
   endtask
   task automatic t_arb();
      int n;
      bit cpu_seen;
      tick(1);
      cpu_addr = 16'h3000;
      cpu_word = 1'b1;
      dbg_addr = 18'h0_3002;
      dbg_word = 1'b1;
      cpu_req = 1'b1;
      dbg_req = 1'b1;
      cpu_seen = 0;
      for (n = 0; n < 300 && d_done !== 1'b1; n++) begin
         tick(1);
         if (c_done === 1'b1)
            cpu_seen = 1;
      end
      check("cpu first", cpu_seen, 1);
      // Cpu kept requesting, so debug waits out the full count
      check("debug wait", n > 128 && n < 145, 1);
      cpu_req = 1'b0;
      dbg_req = 1'b0;
      $display("arbitration test done");
   endtask
   task automatic t_illegal();
      sc = 1'b0;
      go(1'b0, 18'h0_0400, 1'b1, 1'b0);
      sc = 1'b1;
      check("outside single chip", illegal, 0);
      go(1'b0, 18'h0_0400, 1'b1, 1'b1);
      check("firmware access", illegal, 0);
      go(1'b0, 18'h0_0400, 1'b1, 1'b0);
      tick(1);
      check("illegal reset", illegal, 1);
      rst_n = 1'b0;
      tick(2);
      rst_n = 1'b1;
      tick(1);
      check("cleared", illegal, 0);
      check("page after reset", link.page, 8'h0e);
      $display("illegal test done");
   endtask
   initial begin
      tick(8);
      rst_n = 1'b1;
      tick(1);
      check("reset page", link.page, 8'h0e);
      check("irq", irq, 0);
      t_map();
      t_align();
      t_call();
      t_arb();
      t_illegal();
      check("irq", irq, 0);
      results();
   end
endmodule

// [testbench/mmd_link_props.sv]
module mmd_link_props (
   input wire logic        clk_in,
   input wire logic        rst_n_in,
   input wire logic        cpu_req,
   input wire logic        cpu_ack,
   input wire logic        cpu_page_wr,
   input wire logic [7:0]  cpu_page_val,
   input wire logic        dbg_req,
   input wire logic        dbg_word,
   input wire logic [17:0] dbg_addr,
   input wire logic        dbg_ack,
   input wire logic [7:0]  page
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   logic [8:0] wait_cnt;
   // Debug wait counter, saturating so it never wraps past the bound
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in)
         wait_cnt <= 9'h000;
      else if (!dbg_req || dbg_ack)
         wait_cnt <= 9'h000;
      else if (wait_cnt != 9'h1ff)
         wait_cnt <= wait_cnt + 9'h001;
   end
   AST_PAGE_RST: assert property ($rose(rst_n_in) |-> page == 8'h0e)
      else $error("page index not at reset value");
   AST_PAGE_LOAD: assert property (cpu_page_wr |=> page == $past(cpu_page_val))
      else $error("page index not loaded");
   AST_PAGE_STEADY: assert property ($changed(page) |-> $past(cpu_page_wr))
      else $error("page index changed without a write");
   AST_ONE_MASTER: assert property (!(cpu_ack && dbg_ack))
      else $error("both masters answered together");
   AST_CPU_ACK_PULSE: assert property (cpu_ack |=> !cpu_ack)
      else $error("cpu answer longer than one cycle");
   AST_DBG_ACK_PULSE: assert property (dbg_ack |=> !dbg_ack)
      else $error("debug answer longer than one cycle");
   AST_CPU_FIRST: assert property ($rose(cpu_req) && $rose(dbg_req) |->
      !dbg_ack throughout (##[1:8] cpu_ack))
      else $error("cpu did not win contention");
   AST_DBG_BOUND: assert property (wait_cnt <= 9'h090)
      else $error("debug master starved");
   AST_DBG_ALIGN: assert property (dbg_req && dbg_word |-> !dbg_addr[0])
      else $error("misaligned debug word access");
   AST_ACK_CAUSE: assert property (cpu_ack |-> $past(cpu_req))
      else $error("cpu answer without request");
endmodule
